// ===== src/usb_obs_pkg.sv
// package: register map, field positions and types for the usb packet observe block
package usb_obs_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_LAST_PID   = 8'h2c;
    localparam logic [7:0] OFF_LAST_EP    = 8'h30;
    localparam logic [7:0] OFF_EP_MARK    = 8'h34;
    localparam logic [7:0] OFF_OTG_MASK   = 8'h38;
    localparam logic [7:0] OFF_PWR_SIG    = 8'h3c;
    localparam logic [7:0] OFF_PHY_CTRL   = 8'h40;
    localparam logic [7:0] OFF_IRQ_STAT   = 8'h44;
    localparam logic [7:0] OFF_IRQ_MASK   = 8'h48;

    // field positions
    localparam int EP_VALID_BIT     = 4;
    localparam int PWR_VALID_BIT    = 8;
    localparam int PHY_PD_DIS_BIT   = 18;
    localparam int PHY_RES_SE0_BIT  = 13;
    localparam int PHY_RES_K_BIT    = 12;
    localparam int PHY_FILT_LSB     = 8;
    localparam int PHY_AUTO_RES_BIT = 7;
    localparam int PHY_CONF_LSB     = 4;
    localparam int IRQ_PKT_BIT      = 0;
    localparam int IRQ_RESUME_BIT   = 1;
    localparam int IRQ_BITS         = 2;

    // reset values
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;

    // marked endpoints carry this value or-ed in
    localparam logic [4:0] EP_MARK_OR = 5'h10;

    // line state codes
    localparam logic [1:0] LS_SE0 = 2'h0;
    localparam logic [1:0] LS_K   = 2'h2;

    // line state filter counter width, enough for 2^15 clocks
    localparam int FILT_CNT_W = 16;

    // one received packet as reported by the receive path
    typedef struct packed {
        logic       valid;   // one-cycle strobe
        logic [3:0] pid;
        logic [3:0] ep;
        logic       has_ep;  // packet carried an endpoint field
    } pkt_info_t;

    // controls driven to the transceiver
    typedef struct packed {
        logic       pulldown_dis;
        logic [2:0] config_pins;
    } phy_pins_t;

endpackage

// ===== src/usb_packet_observe_phy_control.sv
// usb interface module: packet observe registers and phy control, ahb-lite slave
//
// Contract
// - pid of every received packet is captured into a 4-bit read-only field.
// - endpoint number of the latest received packet is stored read-only.
// - bit 4 of endpoint register flags that endpoint field holds valid value.
// - 16-bit writable endpoint mark mask, one bit per endpoint, resets zero.
// - marked endpoint appears on receive port or-ed with 0x10.
// - phy control bit 18 set disables pulldowns on both wide data ports.
// - auto-resume by se0 reset sets phy control bit 13.
// - auto-resume by k-state sets phy control bit 12.
// - line state change passes only after 2^N stable clocks, N in bits 11:8.
// - bit 7 set lets suspend controller resume from suspend automatically.
// - bits 6:4 drive the three transceiver config pins directly.
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/100ps

module usb_packet_observe_phy_control
    import usb_obs_pkg::*;
(
    // clock and reset
    input  wire logic            hclk,
    input  wire logic            hresetn,
    // ahb-lite slave
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic                 hreadyout,
    output logic                 hresp,
    output logic [31:0]          hrdata,
    // receive path, same clock
    input  wire pkt_info_t       pkt_in,
    output logic [4:0]           rx_port_ep,
    // transceiver side
    input  wire logic [1:0]      phy_linestate,
    output phy_pins_t            phy_pins,
    output logic [1:0]           linestate_filt,
    // suspend controller
    input  wire logic            suspend_active,
    output logic                 resume_req,
    // misc stores
    output logic [31:0]          otg_flag_mask,
    output logic [7:0]           power_sig_data,
    output logic                 power_sig_valid,
    // interrupt
    output logic                 irq
);

    // register state
    logic [3:0]            pid_r;
    logic [3:0]            ep_r;
    logic                  ep_valid_r;
    logic [15:0]           ep_mark_r;
    logic [31:0]           otg_mask_r;
    logic [7:0]            pwr_data_r;
    logic                  pwr_valid_r;
    logic                  pd_dis_r;
    logic                  res_se0_r;
    logic                  res_k_r;
    logic [3:0]            filt_log2_r;
    logic                  auto_res_r;
    logic [2:0]            conf_r;
    logic [IRQ_BITS-1:0]   irq_stat_r;
    logic [IRQ_BITS-1:0]   irq_mask_r;
    logic [4:0]            rx_ep_r;

    // bus data phase
    logic                  dp_wr_r;
    logic [7:0]            dp_addr_r;
    logic                  addr_ok;

    // line state path
    logic [1:0]            ls_meta_r;
    logic [1:0]            ls_sync_r;
    logic [1:0]            ls_prev_r;
    logic [1:0]            ls_filt_r;
    logic [FILT_CNT_W-1:0] filt_cnt_r;
    logic [FILT_CNT_W-1:0] filt_lim;
    logic                  filt_upd;
    logic                  resume_ev;
    logic                  resume_r;

    // single-word zero-wait slave, always okay
    assign addr_ok   = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // address phase captured; reads and writes both use it in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_r   <= 1'b0;
            dp_addr_r <= 8'h00;
        end else if (hready) begin
            dp_wr_r   <= addr_ok & hwrite;
            dp_addr_r <= addr_ok ? {haddr[7:2], 2'b00} : 8'h00;
        end
    end

    // read mux over flops; unmapped and reserved bits read zero
    always_comb begin
        hrdata = RST_ZERO;
        case (dp_addr_r)
            OFF_LAST_PID: hrdata[3:0] = pid_r;
            OFF_LAST_EP:  hrdata[4:0] = {ep_valid_r, ep_r};
            OFF_EP_MARK:  hrdata[15:0] = ep_mark_r;
            OFF_OTG_MASK: hrdata = otg_mask_r;
            OFF_PWR_SIG:  hrdata[PWR_VALID_BIT:0] = {pwr_valid_r, pwr_data_r};
            OFF_PHY_CTRL: begin
                hrdata[PHY_PD_DIS_BIT]                = pd_dis_r;
                hrdata[PHY_RES_SE0_BIT]               = res_se0_r;
                hrdata[PHY_RES_K_BIT]                 = res_k_r;
                hrdata[PHY_FILT_LSB+3:PHY_FILT_LSB]   = filt_log2_r;
                hrdata[PHY_AUTO_RES_BIT]              = auto_res_r;
                hrdata[PHY_CONF_LSB+2:PHY_CONF_LSB]   = conf_r;
            end
            OFF_IRQ_STAT: hrdata[IRQ_BITS-1:0] = irq_stat_r;
            OFF_IRQ_MASK: hrdata[IRQ_BITS-1:0] = irq_mask_r;
            default:      hrdata = RST_ZERO;
        endcase
    end

    // packet capture; endpoint only updates when the packet carried one
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pid_r      <= 4'h0;
            ep_r       <= 4'h0;
            ep_valid_r <= 1'b0;
            rx_ep_r    <= 5'h00;
        end else if (pkt_in.valid) begin
            pid_r      <= pkt_in.pid;
            ep_valid_r <= pkt_in.has_ep;
            if (pkt_in.has_ep) begin
                ep_r    <= pkt_in.ep;
                rx_ep_r <= ep_mark_r[pkt_in.ep] ? ({1'b0, pkt_in.ep} | EP_MARK_OR)
                                                : {1'b0, pkt_in.ep};
            end
        end
    end

    // plain software stores; reserved bits never stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ep_mark_r   <= 16'h0000;
            otg_mask_r  <= RST_ZERO;
            pwr_data_r  <= 8'h00;
            pwr_valid_r <= 1'b0;
            pd_dis_r    <= 1'b0;
            filt_log2_r <= 4'h0;
            auto_res_r  <= 1'b0;
            conf_r      <= 3'h0;
            irq_mask_r  <= '0;
        end else if (dp_wr_r) begin
            case (dp_addr_r)
                OFF_EP_MARK:  ep_mark_r <= hwdata[15:0];
                OFF_OTG_MASK: otg_mask_r <= hwdata;
                OFF_PWR_SIG: begin
                    pwr_data_r  <= hwdata[7:0];
                    pwr_valid_r <= hwdata[PWR_VALID_BIT];
                end
                OFF_PHY_CTRL: begin
                    pd_dis_r    <= hwdata[PHY_PD_DIS_BIT];
                    filt_log2_r <= hwdata[PHY_FILT_LSB+3:PHY_FILT_LSB];
                    auto_res_r  <= hwdata[PHY_AUTO_RES_BIT];
                    conf_r      <= hwdata[PHY_CONF_LSB+2:PHY_CONF_LSB];
                end
                OFF_IRQ_MASK: irq_mask_r <= hwdata[IRQ_BITS-1:0];
                default: ;
            endcase
        end
    end

    // line state pins cross into hclk through two flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ls_meta_r <= 2'h0;
            ls_sync_r <= 2'h0;
            ls_prev_r <= 2'h0;
        end else begin
            ls_meta_r <= phy_linestate;
            ls_sync_r <= ls_meta_r;
            ls_prev_r <= ls_sync_r;
        end
    end

    // new state must hold 2^N clocks before it is passed on
    assign filt_lim = (FILT_CNT_W'(1) << filt_log2_r) - FILT_CNT_W'(1);
    assign filt_upd = (ls_sync_r == ls_prev_r) && (ls_sync_r != ls_filt_r)
                      && (filt_cnt_r >= filt_lim);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            filt_cnt_r <= '0;
            ls_filt_r  <= 2'h0;
        end else if (ls_sync_r != ls_prev_r || ls_sync_r == ls_filt_r) begin
            filt_cnt_r <= '0;
        end else if (filt_upd) begin
            ls_filt_r  <= ls_sync_r;
            filt_cnt_r <= '0;
        end else begin
            filt_cnt_r <= filt_cnt_r + FILT_CNT_W'(1);
        end
    end

    // wake-up seen on the filtered state while suspended and auto mode on
    assign resume_ev = filt_upd & suspend_active & auto_res_r
                       & (ls_sync_r == LS_SE0 || ls_sync_r == LS_K);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            resume_r <= 1'b0;
        end else begin
            resume_r <= resume_ev;
        end
    end

    // cause bits: hardware set beats a software clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            res_se0_r <= 1'b0;
            res_k_r   <= 1'b0;
        end else begin
            if (resume_ev && ls_sync_r == LS_SE0) begin
                res_se0_r <= 1'b1;
            end else if (dp_wr_r && dp_addr_r == OFF_PHY_CTRL && !hwdata[PHY_RES_SE0_BIT]) begin
                res_se0_r <= 1'b0;
            end
            if (resume_ev && ls_sync_r == LS_K) begin
                res_k_r <= 1'b1;
            end else if (dp_wr_r && dp_addr_r == OFF_PHY_CTRL && !hwdata[PHY_RES_K_BIT]) begin
                res_k_r <= 1'b0;
            end
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_r <= '0;
        end else begin
            for (int i = 0; i < IRQ_BITS; i++) begin
                if ((i == IRQ_PKT_BIT && pkt_in.valid) || (i == IRQ_RESUME_BIT && resume_ev)) begin
                    irq_stat_r[i] <= 1'b1;
                end else if (dp_wr_r && dp_addr_r == OFF_IRQ_STAT && hwdata[i]) begin
                    irq_stat_r[i] <= 1'b0;
                end
            end
        end
    end

    // outputs straight from flops, except irq, which is the or of the status flops gated by the mask flops
    assign rx_port_ep            = rx_ep_r;
    assign phy_pins.pulldown_dis = pd_dis_r;
    assign phy_pins.config_pins  = conf_r;
    assign linestate_filt        = ls_filt_r;
    assign resume_req            = resume_r;
    assign otg_flag_mask         = otg_mask_r;
    assign power_sig_data        = pwr_data_r;
    assign power_sig_valid       = pwr_valid_r;
    assign irq                   = |(irq_stat_r & irq_mask_r);

    // checks
    property p_pid_cap;
        @(posedge hclk) disable iff (!hresetn)
        pkt_in.valid |=> pid_r == $past(pkt_in.pid);
    endproperty
    a_pid_cap: assert property (p_pid_cap) else $error("pid not captured");

    property p_ep_cap;
        @(posedge hclk) disable iff (!hresetn)
        pkt_in.valid && pkt_in.has_ep |=> ep_r == $past(pkt_in.ep) && ep_valid_r;
    endproperty
    a_ep_cap: assert property (p_ep_cap) else $error("endpoint not captured");

    property p_ep_invalid;
        @(posedge hclk) disable iff (!hresetn)
        pkt_in.valid && !pkt_in.has_ep |=> !ep_valid_r;
    endproperty
    a_ep_invalid: assert property (p_ep_invalid) else $error("valid bit stuck");

    property p_mark_or;
        @(posedge hclk) disable iff (!hresetn)
        pkt_in.valid && pkt_in.has_ep |=> rx_port_ep[4] == $past(ep_mark_r[pkt_in.ep])
            && rx_port_ep[3:0] == $past(pkt_in.ep);
    endproperty
    a_mark_or: assert property (p_mark_or) else $error("mark tag wrong");

    property p_pd_dis;
        @(posedge hclk) disable iff (!hresetn)
        dp_wr_r && dp_addr_r == OFF_PHY_CTRL |=> phy_pins.pulldown_dis == $past(hwdata[18])
            && phy_pins.config_pins == $past(hwdata[PHY_CONF_LSB+2:PHY_CONF_LSB]);
    endproperty
    a_pd_dis: assert property (p_pd_dis) else $error("pulldown control wrong");

    property p_se0_cause;
        @(posedge hclk) disable iff (!hresetn)
        resume_ev && ls_sync_r == LS_SE0 |=> res_se0_r && resume_req;
    endproperty
    a_se0_cause: assert property (p_se0_cause) else $error("se0 cause not set");

    property p_k_cause;
        @(posedge hclk) disable iff (!hresetn)
        resume_ev && ls_sync_r == LS_K |=> res_k_r && resume_req;
    endproperty
    a_k_cause: assert property (p_k_cause) else $error("k cause not set");

    property p_cause_hold;
        @(posedge hclk) disable iff (!hresetn)
        res_k_r && !(dp_wr_r && dp_addr_r == OFF_PHY_CTRL) |=> res_k_r;
    endproperty
    a_cause_hold: assert property (p_cause_hold) else $error("cause bit lost");

    property p_filt_hold;
        @(posedge hclk) disable iff (!hresetn)
        ls_filt_r != $past(ls_filt_r) |-> $past(ls_sync_r) == ls_filt_r
            && $past(filt_cnt_r) >= $past(filt_lim);
    endproperty
    a_filt_hold: assert property (p_filt_hold) else $error("line state passed early");

    property p_no_auto;
        @(posedge hclk) disable iff (!hresetn)
        !auto_res_r |=> !resume_req;
    endproperty
    a_no_auto: assert property (p_no_auto) else $error("resume without auto mode");

    property p_rsvd;
        @(posedge hclk) disable iff (!hresetn)
        dp_addr_r == OFF_PHY_CTRL |-> hrdata[31:19] == 13'h0000 && hrdata[17:14] == 4'h0
            && hrdata[3:0] == 4'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

endmodule

// ===== verif/phy_line_model.sv
// transceiver stand-in: drives the line state pins seen by the block
`timescale 1ns/100ps

module phy_line_model
    import usb_obs_pkg::*;
(
    // command from the bench
    input  wire logic [1:0]  line_cmd,
    // controls coming back from the block
    input  wire phy_pins_t   phy_pins,
    // line state pins
    output logic [1:0]       phy_linestate
);
    logic [2:0] config_seen;

    // pins move 1.3 ns after a command, so they never land on a clock edge;
    // the block must synchronise them like any asynchronous pin
    // a continuous assignment also settles the idle level 1.3 ns after time zero
    assign #1.3 phy_linestate = line_cmd;

    // the transceiver just latches its configuration level
    always @(phy_pins) begin
        config_seen = phy_pins.config_pins;
    end
endmodule

// ===== verif/usb_packet_observe_phy_control_bench.sv
// bench: register map, packet capture, endpoint marking, line filter, auto-resume
`timescale 1ns/100ps

module usb_packet_observe_phy_control_bench;
    import usb_obs_pkg::*;

    localparam logic [1:0] LS_J = 2'h1;

    logic        hclk, hresetn, hsel, hwrite, hresp, suspend_active;
    logic        resume_req, irq, power_sig_valid;
    logic        hreadyout;
    wire logic   hready;
    logic [31:0] haddr, hwdata, hrdata, otg_flag_mask;
    logic [1:0]  htrans, phy_linestate, linestate_filt, line_cmd;
    logic [2:0]  hsize;
    logic [4:0]  rx_port_ep;
    logic [7:0]  power_sig_data;
    pkt_info_t   pkt_in;
    phy_pins_t   phy_pins;
    int          errors, total_checks;

    // single slave, so its ready is the bus ready
    assign hready = hreadyout;

    usb_packet_observe_phy_control dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pkt_in(pkt_in),
        .rx_port_ep(rx_port_ep), .phy_linestate(phy_linestate), .phy_pins(phy_pins),
        .linestate_filt(linestate_filt), .suspend_active(suspend_active),
        .resume_req(resume_req), .otg_flag_mask(otg_flag_mask),
        .power_sig_data(power_sig_data), .power_sig_valid(power_sig_valid), .irq(irq)
    );

    phy_line_model phy_u (
        .line_cmd(line_cmd), .phy_pins(phy_pins), .phy_linestate(phy_linestate)
    );

    // clock: 4 ns period
    always begin
        #2 hclk = ~hclk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one single word transfer; waits on ready, only the watchdog ends a hang
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        haddr <= {24'h0, a};
        do begin
            @(posedge hclk);
        end while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do begin
            @(posedge hclk);
        end while (hready !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string w);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(w, e, q);
    endtask

    task automatic pkt(input logic [3:0] p, input logic [3:0] e, input logic h);
        pkt_in <= '{valid: 1'b1, pid: p, ep: e, has_ep: h};
        @(posedge hclk);
        pkt_in.valid <= 1'b0;
        @(posedge hclk);
    endtask

    task automatic line(input logic [1:0] v, input int n);
        line_cmd <= v;
        repeat (n) @(posedge hclk);
    endtask

    // counts resume pulses over a bounded span
    task automatic resume_count(output int seen);
        seen = 0;
        repeat (12) begin
            @(posedge hclk);
            if (resume_req === 1'b1) seen++;
        end
    endtask

    task automatic t_reset;
        for (int a = 'h2c; a <= 'h50; a += 4) begin
            rd(a[7:0], 32'h0, "reset or unmapped read");
            chk("ready and okay response", 32'h2, {30'h0, hreadyout, hresp});
        end
        chk("phy pins at reset", 32'h0, {28'h0, phy_pins});
    endtask

    task automatic t_packet;
        wr(OFF_IRQ_MASK, 32'h1);
        pkt(4'h9, 4'h7, 1'b1);
        chk("irq on packet", 32'h1, {31'h0, irq});
        rd(OFF_LAST_PID, 32'h9, "pid");
        rd(OFF_LAST_EP, 32'h17, "endpoint with valid");
        pkt(4'h3, 4'h2, 1'b0);
        rd(OFF_LAST_PID, 32'h3, "pid second");
        rd(OFF_LAST_EP, 32'h07, "endpoint kept, not valid");
        wr(OFF_IRQ_STAT, 32'h1);
        // the clear lands on the edge that ends the write, so look one edge later
        @(posedge hclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
    endtask

    task automatic t_mark;
        wr(OFF_EP_MARK, 32'hffff_8020);
        rd(OFF_EP_MARK, 32'h8020, "mark mask");
        pkt(4'h1, 4'h5, 1'b1);
        chk("marked endpoint", 32'h15, {27'h0, rx_port_ep});
        pkt(4'h1, 4'h6, 1'b1);
        chk("plain endpoint", 32'h06, {27'h0, rx_port_ep});
        pkt(4'h1, 4'hf, 1'b1);
        chk("top endpoint", 32'h1f, {27'h0, rx_port_ep});
    endtask

    task automatic t_stores;
        wr(OFF_OTG_MASK, 32'ha5c3_0ff1);
        rd(OFF_OTG_MASK, 32'ha5c3_0ff1, "otg mask");
        chk("otg output", 32'ha5c3_0ff1, otg_flag_mask);
        wr(OFF_PWR_SIG, 32'hffff_ffff);
        rd(OFF_PWR_SIG, 32'h1ff, "power word");
        chk("power outputs", 32'h1ff, {23'h0, power_sig_valid, power_sig_data});
        wr(OFF_LAST_PID, 32'hffff_ffff);
        rd(OFF_LAST_PID, 32'h1, "read-only pid");
    endtask

    task automatic t_phy;
        wr(OFF_PHY_CTRL, 32'hffff_ffff);
        rd(OFF_PHY_CTRL, 32'h0004_0ff0, "phy control");
        chk("pins all set", 32'hf, {28'h0, phy_pins});
        wr(OFF_PHY_CTRL, 32'h0000_0050);
        @(posedge hclk);
        chk("pins config only", 32'h5, {28'h0, phy_pins});
    endtask

    // n = 2: a change must stand four synced cycles
    task automatic t_filter;
        int n;
        wr(OFF_PHY_CTRL, 32'h0000_0200);
        line(LS_K, 2);
        line(LS_J, 12);
        chk("glitch held back", LS_J, linestate_filt);
        line(LS_K, 4);
        chk("change not yet passed", LS_J, linestate_filt);
        n = 0;
        while (linestate_filt !== LS_K && n < 12) begin
            @(posedge hclk);
            n++;
        end
        chk("change passed", LS_K, linestate_filt);
    endtask

    task automatic t_resume;
        int seen;
        wr(OFF_PHY_CTRL, 32'h0);
        suspend_active <= 1'b1;
        line(LS_J, 8);
        wr(OFF_IRQ_MASK, 32'h2);
        line(LS_K, 0);
        resume_count(seen);
        chk("no resume when manual", 32'h0, seen);
        chk("software sees k", LS_K, linestate_filt);
        rd(OFF_PHY_CTRL, 32'h0, "no cause when manual");
        line(LS_J, 8);
        wr(OFF_PHY_CTRL, 32'h80);
        line(LS_K, 0);
        resume_count(seen);
        chk("resume pulse k", 32'h1, seen);
        rd(OFF_PHY_CTRL, 32'h1080, "k cause");
        chk("irq on resume", 32'h1, {31'h0, irq});
        wr(OFF_PHY_CTRL, 32'h1080);
        rd(OFF_PHY_CTRL, 32'h1080, "cause kept on one");
        wr(OFF_PHY_CTRL, 32'h80);
        rd(OFF_PHY_CTRL, 32'h80, "cause cleared");
        // packet bit is still set from the marking scenario, nobody cleared it
        rd(OFF_IRQ_STAT, 32'h3, "resume status");
        wr(OFF_IRQ_STAT, 32'h2);
        @(posedge hclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        line(LS_J, 8);
        line(LS_SE0, 0);
        resume_count(seen);
        chk("resume pulse se0", 32'h1, seen);
        rd(OFF_PHY_CTRL, 32'h2080, "se0 cause");
        suspend_active <= 1'b0;
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // watchdog: the whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge hclk);
        errors++;
        wrap_up();
    end

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        pkt_in = '0;
        suspend_active = 1'b0;
        line_cmd = LS_J;
        errors = 0;
        total_checks = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_packet();
        t_mark();
        t_stores();
        t_phy();
        t_filter();
        t_resume();
        wrap_up();
    end
endmodule
